// [vecr_pkg.sv]
package vecr_pkg;

    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [7:0] VECR_IDX_VBLANK_STATUS = 8'h02;
    localparam logic [7:0] VECR_IDX_HUE_ADJUST    = 8'h03;
    localparam logic [7:0] VECR_IDX_TIMING_INPUT  = 8'h04;
    localparam logic [7:0] VECR_IDX_DAC_ACTIVE    = 8'h05;
    localparam logic [7:0] VECR_IDX_RESERVED_06   = 8'h06;
    localparam logic [7:0] VECR_IDX_SYNC_LUMA     = 8'h07;
    localparam int         VECR_IDX_OVERLAY_BIT   = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] VECR_RST_HUE_ADJUST   = 8'h00;
    localparam logic [7:0] VECR_RST_TIMING_INPUT = 8'h00;
    localparam logic [7:0] VECR_RST_DAC_ACTIVE   = 8'h25;
    localparam logic [7:0] VECR_RST_RESERVED_06  = 8'h07;
    localparam logic [7:0] VECR_RST_SYNC_LUMA    = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int VECR_BIT_INT_CLEAR     = 0;
    localparam int VECR_BIT_STATUS_ONE    = 1;
    localparam int VECR_BIT_VBLANK        = 2;
    localparam int VECR_BIT_TIMING_MODE   = 0;
    localparam int VECR_BIT_INPUT_FORMAT  = 1;
    localparam int VECR_BIT_OUT_CLK_RATE  = 2;
    localparam int VECR_BIT_INTERP_FIELD  = 3;
    localparam int VECR_POS_ACTIVE_START  = 0;
    localparam int VECR_W_ACTIVE_START    = 3;
    localparam int VECR_BIT_COMPOSITE_DAC = 5;
    localparam int VECR_BIT_SEPARATE_DAC  = 6;
    localparam int VECR_BIT_COLOUR_KILL   = 0;
    localparam int VECR_BIT_LUMA_DELAY    = 1;
    localparam int VECR_BIT_FIELD_SOURCE  = 2;
    localparam int VECR_BIT_SYNC_SOURCE   = 3;
    localparam int VECR_BIT_EXTRA_SHIFT   = 4;

    // ------------------------------------------------------------
    // Timing figures
    // ------------------------------------------------------------
    localparam int VECR_FIRST_PIXEL_NTSC   = 122;
    localparam int VECR_FIRST_PIXEL_PAL    = 132;
    localparam int VECR_OFFSET_BASE        = 11;
    localparam int VECR_OFFSET_STEP        = 2;
    localparam int VECR_HUE_STEP_MICRODEG  = 1406250;

endpackage : vecr_pkg

// [vecr_sync2.sv]
`timescale 1ns/1ps
module vecr_sync2 #(
    parameter int               WIDTH   = 1,
    // Reset to the idle level of each pin, so no false edge follows reset
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             CLOCK,
    input  wire logic             RESET,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            meta <= RST_VAL;
            q    <= RST_VAL;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : vecr_sync2

// [vecr_regs.sv]
// Contract
// R1 - Writing one to clear releases interrupt high
// R2 - Vertical blank reads inverted vertical sync
// R3 - Host updates overlay only during blank
// R4 - Hue adjust unsigned, 1.40625 degree steps
// R5 - Timing mode: zero slave, one master
// R6 - Input format: zero 601, one 656
// R7 - Clock rate: 13.5 or 27 MHz
// R8 - Interp field: even only, or both
// R9 - First active pixel 122, PAL 132
// R10 - Active start offset 11 minus twice code
// R11 - Composite DAC enable, default on
// R12 - Separate video DACs enable, default off
// R13 - Colour kill: monochrome, burst kept
// R14 - Luma delay adds one 27 MHz clock
// R15 - Field source: syncs or odd pin
// R16 - Sync source: pins or embedded code
// R17 - Extra shift adds one 27 MHz clock
// R18 - Index bit 4 selects overlay RAM
// R19 - Host writes synchronised, applied cleanly
`timescale 1ns/1ps
module vecr_regs
    import vecr_pkg::*;
#(
    parameter int DATA_W = 8
) (
    input  wire logic              CLOCK,
    input  wire logic              RESET,
    input  wire logic              CS_N,
    input  wire logic              READ_NOT_WRITE,
    input  wire logic              ADDR_SEL,
    input  wire logic [DATA_W-1:0] DATA_IN,
    output logic      [DATA_W-1:0] DATA_OUT,
    output logic                   DATA_OE,
    input  wire logic              VERTICAL_SYNC_IN_N,
    input  wire logic              INTERRUPT_SET,
    input  wire logic              LINE_START,
    input  wire logic              PAL_SELECT,
    input  wire logic              CLOCK_INPUT_27M_SEL,
    output logic                   INTERRUPT_OUT_N,
    output logic [7:0]             HUE_ADJUST,
    output logic                   TIMING_MASTER,
    output logic                   INPUT_FORMAT_656,
    output logic                   OUTPUT_CLOCK_27M,
    output logic                   INTERP_BOTH_FIELDS,
    output logic [8:0]             FIRST_PIXEL_DELAY_27M,
    output logic                   COMPOSITE_DAC_ENABLE,
    output logic                   SEPARATE_VIDEO_DAC_ENABLE,
    output logic                   COLOUR_KILL,
    output logic                   LUMA_DELAY,
    output logic                   FIELD_FROM_ODD_PIN,
    output logic                   SYNC_FROM_EAV,
    output logic                   OVERLAY_WRITE,
    output logic [3:0]             OVERLAY_ADDR,
    output logic [7:0]             OVERLAY_DATA
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Host strobes come from an unclocked port, so all of them pass
    // two flops before decoding.
    localparam int SYNC_W = 4 + DATA_W;
    logic [SYNC_W-1:0] sync_q;
    logic              cs_n_s;
    logic              rnw_s;
    logic              a0_s;
    logic              vsync_n_s;
    logic [7:0]        din_s;

    vecr_sync2 #(.WIDTH(SYNC_W), .RST_VAL({4'h9, {DATA_W{1'b0}}})) u_sync (
        .CLOCK (CLOCK),
        .RESET (RESET),
        .d     ({CS_N, READ_NOT_WRITE, ADDR_SEL, VERTICAL_SYNC_IN_N, DATA_IN}), // R19
        .q     (sync_q)
    );

    assign cs_n_s    = sync_q[SYNC_W-1];
    assign rnw_s     = sync_q[SYNC_W-2];
    assign a0_s      = sync_q[SYNC_W-3];
    assign vsync_n_s = sync_q[SYNC_W-4];
    assign din_s     = sync_q[7:0];

    // ------------------------------------------------------------
    // Strobe edge detection
    // ------------------------------------------------------------
    logic cs_n_d;
    wire  cs_rise   = cs_n_s & ~cs_n_d;
    wire  cs_fall   = ~cs_n_s & cs_n_d;
    // Data is latched at the rising edge of chip select, where the
    // host guarantees it stable, so a write lands once per access.
    wire  wr_stb    = cs_rise & ~rnw_s;
    wire  wr_index  = wr_stb & ~a0_s;
    wire  wr_data   = wr_stb & a0_s;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0] index;
    logic [7:0] hue_adjust;
    logic [7:0] timing_input_control;
    logic [7:0] dac_and_active_start_control;
    logic [7:0] reserved_06;
    logic [7:0] sync_and_luma_control;
    logic       int_n;
    logic       rd_active;
    logic [7:0] rd_latch;

    wire overlay_sel = index[VECR_IDX_OVERLAY_BIT]; // R18

    function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
        hit = (idx == want);
    endfunction : hit

    wire wr_hue   = wr_data & ~overlay_sel & hit(index, VECR_IDX_HUE_ADJUST);
    wire wr_tic   = wr_data & ~overlay_sel & hit(index, VECR_IDX_TIMING_INPUT);
    wire wr_dac   = wr_data & ~overlay_sel & hit(index, VECR_IDX_DAC_ACTIVE);
    wire wr_res   = wr_data & ~overlay_sel & hit(index, VECR_IDX_RESERVED_06);
    wire wr_sle   = wr_data & ~overlay_sel & hit(index, VECR_IDX_SYNC_LUMA);
    wire wr_vst   = wr_data & ~overlay_sel & hit(index, VECR_IDX_VBLANK_STATUS);
    wire int_clr  = wr_vst & din_s[VECR_BIT_INT_CLEAR]; // R1
    wire wr_ovl   = wr_data & overlay_sel; // R18

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    wire        vblank = ~vsync_n_s; // R2
    logic [7:0] status_byte;
    logic [7:0] rd_mux;

    always_comb begin
        status_byte = 8'h00;
        status_byte[VECR_BIT_VBLANK]     = vblank; // R2
        status_byte[VECR_BIT_STATUS_ONE] = 1'b1;
    end

    assign rd_mux = ~a0_s                                 ? index :
                    hit(index, VECR_IDX_VBLANK_STATUS)    ? status_byte :
                    hit(index, VECR_IDX_HUE_ADJUST)       ? hue_adjust :
                    hit(index, VECR_IDX_TIMING_INPUT)     ? timing_input_control :
                    hit(index, VECR_IDX_DAC_ACTIVE)       ? dac_and_active_start_control :
                    hit(index, VECR_IDX_RESERVED_06)      ? reserved_06 :
                    hit(index, VECR_IDX_SYNC_LUMA)        ? sync_and_luma_control :
                                                            8'h00;

    // ------------------------------------------------------------
    // Host register writes
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            cs_n_d                       <= 1'b1;
            index                        <= 8'h00;
            hue_adjust                   <= VECR_RST_HUE_ADJUST;
            timing_input_control         <= VECR_RST_TIMING_INPUT;
            dac_and_active_start_control <= VECR_RST_DAC_ACTIVE;
            reserved_06                  <= VECR_RST_RESERVED_06;
            sync_and_luma_control        <= VECR_RST_SYNC_LUMA;
        end else begin
            cs_n_d <= cs_n_s;
            if (wr_index) begin
                index <= din_s;
            end
            if (wr_hue) begin
                hue_adjust <= din_s; // R4
            end
            if (wr_tic) begin
                timing_input_control <= din_s;
            end
            if (wr_dac) begin
                dac_and_active_start_control <= din_s;
            end
            if (wr_res) begin
                reserved_06 <= din_s;
            end
            if (wr_sle) begin
                sync_and_luma_control <= din_s;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt output
    // ------------------------------------------------------------
    // A new event outranks a clear arriving in the same cycle.
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            int_n <= 1'b1;
        end else if (INTERRUPT_SET) begin
            int_n <= 1'b0;
        end else if (int_clr) begin
            int_n <= 1'b1; // R1
        end
    end

    // ------------------------------------------------------------
    // Read data port
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            rd_active <= 1'b0;
            rd_latch  <= 8'h00;
        end else begin
            if (cs_fall & rnw_s) begin
                rd_active <= 1'b1;
                rd_latch  <= rd_mux;
            end else if (cs_rise) begin
                rd_active <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Active start position
    // ------------------------------------------------------------
    // Position kept in 27 MHz clocks: halving it would lose the one-clock extra shift.
    wire [2:0] hav_code   = dac_and_active_start_control[VECR_POS_ACTIVE_START +: VECR_W_ACTIVE_START];
    wire       shift_bit  = sync_and_luma_control[VECR_BIT_EXTRA_SHIFT];
    wire [8:0] nominal_27 = PAL_SELECT ? 9'(2 * VECR_FIRST_PIXEL_PAL)
                                       : 9'(2 * VECR_FIRST_PIXEL_NTSC); // R9
    wire [8:0] offset_add = 9'(VECR_OFFSET_BASE) + {8'h00, shift_bit}; // R17
    wire [8:0] offset_sub = 9'(VECR_OFFSET_STEP) * {6'h00, hav_code}; // R10
    wire [8:0] pixel_pos  = nominal_27 + offset_add - offset_sub;

    // ------------------------------------------------------------
    // Settings applied to the encoder
    // ------------------------------------------------------------
    // Settings refresh only at line start, so a change never lands
    // mid-line and glitches active video.
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            HUE_ADJUST                <= VECR_RST_HUE_ADJUST;
            TIMING_MASTER             <= VECR_RST_TIMING_INPUT[VECR_BIT_TIMING_MODE];
            INPUT_FORMAT_656          <= VECR_RST_TIMING_INPUT[VECR_BIT_INPUT_FORMAT];
            OUTPUT_CLOCK_27M          <= VECR_RST_TIMING_INPUT[VECR_BIT_OUT_CLK_RATE];
            INTERP_BOTH_FIELDS        <= VECR_RST_TIMING_INPUT[VECR_BIT_INTERP_FIELD];
            FIRST_PIXEL_DELAY_27M     <= 9'h000;
            COMPOSITE_DAC_ENABLE      <= VECR_RST_DAC_ACTIVE[VECR_BIT_COMPOSITE_DAC];
            SEPARATE_VIDEO_DAC_ENABLE <= VECR_RST_DAC_ACTIVE[VECR_BIT_SEPARATE_DAC];
            COLOUR_KILL               <= VECR_RST_SYNC_LUMA[VECR_BIT_COLOUR_KILL];
            LUMA_DELAY                <= VECR_RST_SYNC_LUMA[VECR_BIT_LUMA_DELAY];
            FIELD_FROM_ODD_PIN        <= VECR_RST_SYNC_LUMA[VECR_BIT_FIELD_SOURCE];
            SYNC_FROM_EAV             <= VECR_RST_SYNC_LUMA[VECR_BIT_SYNC_SOURCE];
        end else if (LINE_START) begin // R19
            HUE_ADJUST                <= hue_adjust; // R4
            TIMING_MASTER             <= timing_input_control[VECR_BIT_TIMING_MODE]; // R5
            INPUT_FORMAT_656          <= timing_input_control[VECR_BIT_INPUT_FORMAT]; // R6
            // 27 MHz output is refused when the 27 MHz input is the source
            OUTPUT_CLOCK_27M          <= timing_input_control[VECR_BIT_OUT_CLK_RATE]
                                         & ~CLOCK_INPUT_27M_SEL; // R7
            INTERP_BOTH_FIELDS        <= timing_input_control[VECR_BIT_INTERP_FIELD]; // R8
            FIRST_PIXEL_DELAY_27M     <= pixel_pos; // R9 R10
            COMPOSITE_DAC_ENABLE      <= dac_and_active_start_control[VECR_BIT_COMPOSITE_DAC]; // R11
            SEPARATE_VIDEO_DAC_ENABLE <= dac_and_active_start_control[VECR_BIT_SEPARATE_DAC]; // R12
            COLOUR_KILL               <= sync_and_luma_control[VECR_BIT_COLOUR_KILL]; // R13
            LUMA_DELAY                <= sync_and_luma_control[VECR_BIT_LUMA_DELAY]; // R14
            FIELD_FROM_ODD_PIN        <= sync_and_luma_control[VECR_BIT_FIELD_SOURCE]; // R15
            SYNC_FROM_EAV             <= sync_and_luma_control[VECR_BIT_SYNC_SOURCE]; // R16
        end
    end

    // ------------------------------------------------------------
    // Overlay write port and outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            OVERLAY_WRITE   <= 1'b0;
            OVERLAY_ADDR    <= 4'h0;
            OVERLAY_DATA    <= 8'h00;
            INTERRUPT_OUT_N <= 1'b1;
            DATA_OUT        <= '0;
            DATA_OE         <= 1'b0;
        end else begin
            OVERLAY_WRITE   <= wr_ovl; // R18
            OVERLAY_ADDR    <= index[3:0];
            OVERLAY_DATA    <= din_s;
            INTERRUPT_OUT_N <= int_n;
            DATA_OUT        <= DATA_W'(rd_latch);
            DATA_OE         <= rd_active & ~cs_rise;
        end
    end

endmodule : vecr_regs

// [vecr_regs_assertions.sv]
`timescale 1ns/1ps
module vecr_regs_assertions (
    input wire logic       CLOCK,
    input wire logic       RESET,
    input wire logic       CS_N,
    input wire logic       READ_NOT_WRITE,
    input wire logic       DATA_OE,
    input wire logic       INTERRUPT_SET,
    input wire logic       INTERRUPT_OUT_N,
    input wire logic       LINE_START,
    input wire logic       PAL_SELECT,
    input wire logic       CLOCK_INPUT_27M_SEL,
    input wire logic       OUTPUT_CLOCK_27M,
    input wire logic [7:0] HUE_ADJUST,
    input wire logic       TIMING_MASTER,
    input wire logic       COLOUR_KILL,
    input wire logic [8:0] FIRST_PIXEL_DELAY_27M,
    input wire logic       OVERLAY_WRITE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_int_set_low: assert property (INTERRUPT_SET |-> ##2 !INTERRUPT_OUT_N) else $error("int not low");
    a_reset_idle: assert property (disable iff (1'b0) RESET |=> INTERRUPT_OUT_N && !DATA_OE)
        else $error("not idle after reset");
    // Settings may only move on a line start, so active video never sees a half update
    a_hold_between: assert property (!LINE_START |=>
        $stable({HUE_ADJUST, TIMING_MASTER, COLOUR_KILL, FIRST_PIXEL_DELAY_27M})) else $error("setting moved");
    a_clk27_refused: assert property (LINE_START && CLOCK_INPUT_27M_SEL |=> !OUTPUT_CLOCK_27M)
        else $error("27 MHz output allowed");
    a_pixel_ntsc: assert property (LINE_START && !PAL_SELECT |=>
        FIRST_PIXEL_DELAY_27M inside {[9'd241:9'd256]}) else $error("ntsc start out of range");
    a_pixel_pal: assert property (LINE_START && PAL_SELECT |=>
        FIRST_PIXEL_DELAY_27M inside {[9'd261:9'd276]}) else $error("pal start out of range");
    a_ovl_pulse: assert property (OVERLAY_WRITE |=> !OVERLAY_WRITE) else $error("overlay pulse long");
    a_ovl_on_write: assert property (OVERLAY_WRITE |-> !READ_NOT_WRITE && $past(CS_N, 2))
        else $error("overlay write without host write");
    a_oe_after_cs: assert property ($rose(DATA_OE) |-> READ_NOT_WRITE && !$past(CS_N, 3))
        else $error("bus driven without read");
    a_oe_until_cs: assert property ($fell(DATA_OE) |-> $past(CS_N, 2)) else $error("bus released early");
    c_master_line: cover property (LINE_START && TIMING_MASTER);
    c_overlay: cover property (OVERLAY_WRITE);
    c_read: cover property ($rose(DATA_OE));
    c_int_clear: cover property (!INTERRUPT_OUT_N ##1 INTERRUPT_OUT_N);
endmodule : vecr_regs_assertions
bind vecr_regs vecr_regs_assertions u_chk (.CLOCK, .RESET, .CS_N, .READ_NOT_WRITE, .DATA_OE, .INTERRUPT_SET,
    .INTERRUPT_OUT_N, .LINE_START, .PAL_SELECT, .CLOCK_INPUT_27M_SEL, .OUTPUT_CLOCK_27M, .HUE_ADJUST,
    .TIMING_MASTER, .COLOUR_KILL, .FIRST_PIXEL_DELAY_27M, .OVERLAY_WRITE);

// [vecr_host_model.sv]
`timescale 1ns/1ps
module vecr_host_model (
    input  wire logic       CLOCK,
    output logic            cs_n,
    output logic            rnw,
    output logic            addr_sel,
    output logic [7:0]      data_in,
    input  wire logic [7:0] data_out
);
    // Strobe widths of the host pins, 150 ns low and 300 ns high, in 5 ns cycles
    localparam int LOW_CYC  = 30;
    localparam int HIGH_CYC = 60;
    initial begin
        cs_n = 1'b1;
        rnw = 1'b1;
        addr_sel = 1'b0;
        data_in = 8'h00;
    end
    task automatic access(input logic a, input logic rd, input logic [7:0] d, output logic [7:0] q);
        @(posedge CLOCK);
        rnw <= rd;
        addr_sel <= a;
        data_in <= rd ? ~data_in : d;
        @(posedge CLOCK);
        cs_n <= 1'b0;
        repeat (LOW_CYC) @(posedge CLOCK);
        q = data_out;
        cs_n <= 1'b1;
        repeat (HIGH_CYC) @(posedge CLOCK);
        // Hold time over: stop showing the old byte
        data_in <= ~data_in;
        addr_sel <= ~a;
    endtask : access
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        access(1'b0, 1'b0, idx, q);
        access(1'b1, 1'b0, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] idx, output logic [7:0] q);
        access(1'b0, 1'b0, idx, q);
        access(1'b1, 1'b1, 8'h00, q);
    endtask : rd
    task automatic ovl_wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] q;
        q = 8'h00;
        for (int i = 0; i < 20 && q[2] !== 1'b1; i++) rd(8'h02, q);
        if (q[2] === 1'b1) wr(idx, d);
    endtask : ovl_wr
endmodule : vecr_host_model

// [testbench.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench;
    import vecr_pkg::*;
    logic       CLOCK, RESET, CS_N, READ_NOT_WRITE, ADDR_SEL, DATA_OE, VERTICAL_SYNC_IN_N, INTERRUPT_SET;
    logic       LINE_START, PAL_SELECT, CLOCK_INPUT_27M_SEL, INTERRUPT_OUT_N, TIMING_MASTER, INPUT_FORMAT_656;
    logic       OUTPUT_CLOCK_27M, INTERP_BOTH_FIELDS, COMPOSITE_DAC_ENABLE, SEPARATE_VIDEO_DAC_ENABLE;
    logic       COLOUR_KILL, LUMA_DELAY, FIELD_FROM_ODD_PIN, SYNC_FROM_EAV, OVERLAY_WRITE;
    logic [3:0] OVERLAY_ADDR, ovl_a;
    logic [7:0] DATA_IN, DATA_OUT, HUE_ADJUST, OVERLAY_DATA, q, ovl_d;
    logic [8:0] FIRST_PIXEL_DELAY_27M;
    int         err_count, samples_checked, cyc, ovl_n;
    vecr_regs dut (.CLOCK, .RESET, .CS_N, .READ_NOT_WRITE, .ADDR_SEL, .DATA_IN, .DATA_OUT, .DATA_OE,
        .VERTICAL_SYNC_IN_N, .INTERRUPT_SET, .LINE_START, .PAL_SELECT, .CLOCK_INPUT_27M_SEL, .INTERRUPT_OUT_N,
        .HUE_ADJUST, .TIMING_MASTER, .INPUT_FORMAT_656, .OUTPUT_CLOCK_27M, .INTERP_BOTH_FIELDS,
        .FIRST_PIXEL_DELAY_27M, .COMPOSITE_DAC_ENABLE, .SEPARATE_VIDEO_DAC_ENABLE, .COLOUR_KILL, .LUMA_DELAY,
        .FIELD_FROM_ODD_PIN, .SYNC_FROM_EAV, .OVERLAY_WRITE, .OVERLAY_ADDR, .OVERLAY_DATA);
    vecr_host_model host (.CLOCK(CLOCK), .cs_n(CS_N), .rnw(READ_NOT_WRITE), .addr_sel(ADDR_SEL),
        .data_in(DATA_IN), .data_out(DATA_OUT));
    initial begin
        CLOCK = 1'b0;
        forever #2.5 CLOCK = ~CLOCK;
    end
    always @(posedge CLOCK) begin
        cyc++;
        if (OVERLAY_WRITE === 1'b1) begin
            ovl_n++;
            ovl_a = OVERLAY_ADDR;
            ovl_d = OVERLAY_DATA;
        end
        if (cyc == 20000) begin
            err_count++;
            results();
        end
    end
    task automatic line_start();
        @(posedge CLOCK) LINE_START <= 1'b1;
        @(posedge CLOCK) LINE_START <= 1'b0;
        @(posedge CLOCK);
        #1;
    endtask : line_start
    task automatic t_reset();
        logic [7:0] idx [5] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
        logic [7:0] exp [5] = '{VECR_RST_HUE_ADJUST, VECR_RST_TIMING_INPUT, VECR_RST_DAC_ACTIVE,
                                VECR_RST_RESERVED_06, VECR_RST_SYNC_LUMA};
        `CHK("int_n", 1'b1, INTERRUPT_OUT_N)
        for (int i = 0; i < 5; i++) begin
            host.rd(idx[i], q);
            `CHK("reset value", exp[i], q)
        end
        line_start();
        `CHK("first pixel", 9'd245, FIRST_PIXEL_DELAY_27M)
        `CHK("dacs", 2'b10, {COMPOSITE_DAC_ENABLE, SEPARATE_VIDEO_DAC_ENABLE})
    endtask : t_reset
    task automatic t_int();
        @(posedge CLOCK) INTERRUPT_SET <= 1'b1;
        @(posedge CLOCK) INTERRUPT_SET <= 1'b0;
        host.wr(8'h02, 8'h00);
        `CHK("int_n kept", 1'b0, INTERRUPT_OUT_N)
        host.wr(8'h02, 8'h01);
        `CHK("int_n cleared", 1'b1, INTERRUPT_OUT_N)
    endtask : t_int
    task automatic t_vblank();
        @(posedge CLOCK) VERTICAL_SYNC_IN_N <= 1'b0;
        host.rd(8'h02, q);
        `CHK("blank on", 2'b11, q[2:1])
        @(posedge CLOCK) VERTICAL_SYNC_IN_N <= 1'b1;
        host.rd(8'h02, q);
        `CHK("blank off", 2'b01, q[2:1])
    endtask : t_vblank
    task automatic t_timing();
        host.wr(8'h04, 8'h0f);
        `CHK("early master", 1'b0, TIMING_MASTER)
        line_start();
        `CHK("reg c", 4'hf, {INTERP_BOTH_FIELDS, OUTPUT_CLOCK_27M, INPUT_FORMAT_656, TIMING_MASTER})
        @(posedge CLOCK) CLOCK_INPUT_27M_SEL <= 1'b1;
        line_start();
        `CHK("27m refused", 1'b0, OUTPUT_CLOCK_27M)
        @(posedge CLOCK) CLOCK_INPUT_27M_SEL <= 1'b0;
    endtask : t_timing
    task automatic t_active();
        logic [7:0] e;
        int         nom;
        for (int c = 0; c < 8; c++) begin
            e = {3'b000, c[0] ^ c[1], c[0], c[1], c[2], ~c[0]};
            nom = c[2] ? VECR_FIRST_PIXEL_PAL : VECR_FIRST_PIXEL_NTSC;
            @(posedge CLOCK) PAL_SELECT <= c[2];
            host.wr(8'h05, 8'h40 | 8'(c));
            host.wr(8'h07, e);
            line_start();
            `CHK("first pixel", 9'(2 * nom + 11 - 2 * c + e[4]), FIRST_PIXEL_DELAY_27M)
            `CHK("dacs", 2'b01, {COMPOSITE_DAC_ENABLE, SEPARATE_VIDEO_DAC_ENABLE})
            `CHK("reg e", e[3:0], {SYNC_FROM_EAV, FIELD_FROM_ODD_PIN, LUMA_DELAY, COLOUR_KILL})
        end
    endtask : t_active
    task automatic t_hue_ovl();
        host.wr(8'h03, 8'hff);
        `CHK("hue early", 8'h00, HUE_ADJUST)
        line_start();
        `CHK("hue", 8'hff, HUE_ADJUST)
        host.wr(8'h08, 8'h5a);
        host.rd(8'h08, q);
        `CHK("unmapped", 8'h00, q)
        @(posedge CLOCK) VERTICAL_SYNC_IN_N <= 1'b0;
        host.ovl_wr(8'hba, 8'h5c);
        `CHK("ovl count", 1, ovl_n)
        `CHK("ovl addr", 4'ha, ovl_a)
        `CHK("ovl data", 8'h5c, ovl_d)
    endtask : t_hue_ovl
    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    initial begin
        {RESET, VERTICAL_SYNC_IN_N} = 2'b11;
        {INTERRUPT_SET, LINE_START, PAL_SELECT, CLOCK_INPUT_27M_SEL} = 4'h0;
        repeat (12) @(posedge CLOCK);
        RESET <= 1'b0;
        @(posedge CLOCK);
        #1;
        t_reset();
        t_int();
        t_vblank();
        t_timing();
        t_active();
        t_hue_ovl();
        results();
    end
endmodule : testbench
